// >>> hdl/adc_config_test_regs.sv
// configuration and test register bank of a dual-core interleaved converter
`include "adc_cfg_params.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_config_test_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic [1:0]  power_state_pin_i,
  input  wire logic [1:0]  divider_select_pin_i,
  input  wire logic [1:0]  output_drive_pin_i,
  input  wire logic [1:0]  output_coding_pin_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  output logic      [1:0]  core0_power_o,
  output logic      [1:0]  core1_power_o,
  output logic      [7:0]  skew_trim_o,
  output logic             clock_div2_o,
  output logic             phase_slip_o,
  output logic      [1:0]  output_drive_o,
  output logic      [1:0]  output_coding_o,
  output logic             ddr_enable_o,
  output logic             dll_slow_o,
  output logic             test_active_o,
  output logic      [15:0] test_data_o
);

  adc_cfg_pkg::state_type cur_ff;
  adc_cfg_pkg::state_type nxt_ff;

  logic [7:0]  pins_raw;
  logic        wr_soft_reset;
  logic        idx_core0;
  logic        idx_core1;
  logic        idx_valid;
  logic [7:0]  status_read;
  logic [15:0] word_one;
  logic [15:0] word_two;
  logic [15:0] pat_word1;
  logic [15:0] pat_word2;
  logic        pat_dual;

  // decode a one-hot field with pin fallback, reserved codes hold
  function automatic adc_cfg_pkg::setting_type pick(
    input logic [2:0]               fld,
    input logic [1:0]               pin,
    input adc_cfg_pkg::setting_type prev
  );
    adc_cfg_pkg::setting_type res;
    res = prev;
    case (fld)
      `MODE_PIN:  res = (pin == 2'h3) ? prev : pin;
      `MODE_SEL0: res = 2'h0;
      `MODE_SEL1: res = 2'h1;
      `MODE_SEL2: res = 2'h2;
      default:    res = prev;
    endcase
    return res;
  endfunction

  assign pins_raw = {output_coding_pin_i, output_drive_pin_i,
                     divider_select_pin_i, power_state_pin_i};

  // core selection from the index register
  assign idx_core0 = (cur_ff.core_index == `INDEX_CORE0);
  assign idx_core1 = (cur_ff.core_index == `INDEX_CORE1);
  assign idx_valid = idx_core0 | idx_core1;

  assign wr_soft_reset = reg_wr_i && (reg_addr_i == `ADDR_PORT_CONFIG)
                         && reg_wdata_i[`SOFT_RESET_BIT];

  // status mirrors the DLL range bit of the secondary format
  always_comb begin
    status_read = `RST_ZERO;
    status_read[`DLL_SLOW_BIT] = cur_ff.format_sec[`DLL_SLOW_BIT];
  end

  // user words; second word upper byte is not kept
  assign word_one = {cur_ff.word1_high, cur_ff.word1_low};
  assign word_two = {8'h00, cur_ff.word2_low};

  // pattern words per test code
  always_comb begin
    pat_word1 = `WORD_ZEROS;
    pat_word2 = `WORD_ZEROS;
    pat_dual  = 1'b0;
    case (cur_ff.eff_pattern)
      `PAT_MID: begin
        pat_word1 = `WORD_MID;
      end
      `PAT_ONES: begin
        pat_word1 = `WORD_ONES;
      end
      `PAT_ZEROS: begin
        pat_word1 = `WORD_ZEROS;
      end
      `PAT_CHECKER: begin
        pat_word1 = `WORD_CHECK_A;
        pat_word2 = `WORD_CHECK_B;
        pat_dual  = 1'b1;
      end
      `PAT_ONE_ZERO: begin
        pat_word1 = `WORD_ONES;
        pat_word2 = `WORD_ZEROS;
        pat_dual  = 1'b1;
      end
      `PAT_USER: begin
        pat_word1 = word_one;
        pat_word2 = word_two;
        pat_dual  = 1'b1;
      end
      default: begin
        pat_word1 = `WORD_ZEROS;
      end
    endcase
  end

  // next state of the whole bank
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.slip_pulse = 1'b0;
    nxt_ff.rd_valid   = 1'b0;

    // two-stage pin synchroniser
    nxt_ff.pin_meta = pins_raw;
    nxt_ff.pin_sync = cur_ff.pin_meta;

    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `ADDR_CORE_INDEX: nxt_ff.core_index = reg_wdata_i;
        `ADDR_POWER_MODE: begin
          if (idx_core0) begin
            nxt_ff.power_core0 = reg_wdata_i;
          end
          if (idx_core1) begin
            nxt_ff.power_core1 = reg_wdata_i;
          end
        end
        `ADDR_SKEW_TRIM:  nxt_ff.skew_trim = reg_wdata_i;
        `ADDR_CLOCK_SLIP: begin
          nxt_ff.clock_slip = reg_wdata_i;
          // rising bit 0 from one write to the next
          if (!cur_ff.clock_slip[`SLIP_BIT] && reg_wdata_i[`SLIP_BIT]
              && (cur_ff.eff_divider == 2'h1)) begin
            nxt_ff.slip_pulse = 1'b1;
          end
        end
        `ADDR_DIVIDER:    nxt_ff.divider = reg_wdata_i;
        `ADDR_FORMAT_PRI: nxt_ff.format_pri = reg_wdata_i;
        // written word is the change against the actual bits
        `ADDR_FORMAT_SEC: nxt_ff.format_sec = cur_ff.format_sec ^ reg_wdata_i;
        `ADDR_TEST_CTRL:  nxt_ff.test_ctrl = reg_wdata_i;
        `ADDR_WORD1_LOW:  nxt_ff.word1_low = reg_wdata_i;
        `ADDR_WORD1_HIGH: nxt_ff.word1_high = reg_wdata_i;
        `ADDR_WORD2_LOW:  nxt_ff.word2_low = reg_wdata_i;
        default: begin
        end
      endcase
    end

    // soft reset; exempt registers keep their contents
    if (wr_soft_reset) begin
      nxt_ff.core_index = `RST_ZERO;
      nxt_ff.skew_trim  = `RST_SKEW;
      nxt_ff.clock_slip = `RST_ZERO;
      nxt_ff.format_sec = `RST_ZERO;
      nxt_ff.test_ctrl  = `RST_ZERO;
      nxt_ff.word1_low  = `RST_ZERO;
      nxt_ff.word1_high = `RST_ZERO;
      nxt_ff.word2_low  = `RST_ZERO;
      nxt_ff.power_core0 = cur_ff.power_core0;
      nxt_ff.power_core1 = cur_ff.power_core1;
      nxt_ff.divider     = cur_ff.divider;
      nxt_ff.format_pri  = cur_ff.format_pri;
    end

    // effective settings; pin codes apply to both cores
    nxt_ff.eff_power0 = pick(cur_ff.power_core0[2:0], cur_ff.pin_sync[1:0],
                             cur_ff.eff_power0);
    nxt_ff.eff_power1 = pick(cur_ff.power_core1[2:0], cur_ff.pin_sync[1:0],
                             cur_ff.eff_power1);
    nxt_ff.eff_divider = pick(cur_ff.divider[2:0], cur_ff.pin_sync[3:2],
                              cur_ff.eff_divider);
    // divide code 100 is forbidden
    if (nxt_ff.eff_divider == 2'h2) begin
      nxt_ff.eff_divider = cur_ff.eff_divider;
    end
    nxt_ff.eff_drive = pick(cur_ff.format_pri[7:5], cur_ff.pin_sync[5:4],
                            cur_ff.eff_drive);
    nxt_ff.eff_coding = pick(cur_ff.format_pri[2:0], cur_ff.pin_sync[7:6],
                             cur_ff.eff_coding);

    // test mode; reserved codes hold the last legal choice
    if (cur_ff.test_ctrl[7:6] == 2'h0 || cur_ff.test_ctrl[7:6] == 2'h1) begin
      nxt_ff.eff_alt = cur_ff.test_ctrl[6];
    end
    if (cur_ff.test_ctrl[3:0] != 4'h5 && cur_ff.test_ctrl[3:0] != 4'h6
        && cur_ff.test_ctrl[3:0] <= `PAT_USER) begin
      nxt_ff.eff_pattern = cur_ff.test_ctrl[3:0];
    end

    // settle counter restarts on any pattern change
    if (nxt_ff.eff_pattern != cur_ff.eff_pattern
        || nxt_ff.eff_alt != cur_ff.eff_alt) begin
      nxt_ff.settle = `TEST_SETTLE;
    end else if (cur_ff.settle != 3'h0) begin
      nxt_ff.settle = cur_ff.settle - 3'h1;
    end

    // drive pattern words; alternate phase each clock
    nxt_ff.phase = ~cur_ff.phase;
    nxt_ff.test_active = (cur_ff.eff_pattern != `PAT_OFF)
                         && (cur_ff.settle == 3'h0);
    if (cur_ff.eff_alt && pat_dual && cur_ff.phase) begin
      nxt_ff.test_data = pat_word2;
    end else begin
      nxt_ff.test_data = pat_word1;
    end
    if (!nxt_ff.test_active) begin
      nxt_ff.test_data = `WORD_ZEROS;
    end

    // register reads, answered one cycle later
    if (reg_rd_i) begin
      nxt_ff.rd_valid = 1'b1;
      case (reg_addr_i)
        `ADDR_CORE_INDEX: nxt_ff.rd_data = cur_ff.core_index;
        `ADDR_POWER_MODE: begin
          if (idx_core0) begin
            nxt_ff.rd_data = cur_ff.power_core0;
          end else if (idx_core1) begin
            nxt_ff.rd_data = cur_ff.power_core1;
          end else begin
            nxt_ff.rd_data = `BAD_INDEX_CODE;
          end
        end
        `ADDR_SKEW_TRIM:  nxt_ff.rd_data = cur_ff.skew_trim;
        `ADDR_CLOCK_SLIP: nxt_ff.rd_data = cur_ff.clock_slip;
        `ADDR_DIVIDER:    nxt_ff.rd_data = cur_ff.divider;
        `ADDR_FORMAT_PRI: nxt_ff.rd_data = cur_ff.format_pri;
        // readback folds in status so the host procedure lands
        `ADDR_FORMAT_SEC: nxt_ff.rd_data = cur_ff.format_sec ^ status_read;
        `ADDR_DLL_STATE:  nxt_ff.rd_data = status_read;
        `ADDR_TEST_CTRL:  nxt_ff.rd_data = cur_ff.test_ctrl;
        `ADDR_WORD1_LOW:  nxt_ff.rd_data = cur_ff.word1_low;
        `ADDR_WORD1_HIGH: nxt_ff.rd_data = cur_ff.word1_high;
        `ADDR_WORD2_LOW:  nxt_ff.rd_data = cur_ff.word2_low;
        default:          nxt_ff.rd_data = `RST_ZERO;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cur_ff <= '0;
      cur_ff.skew_trim <= `RST_SKEW;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // outputs straight from state
  assign reg_rdata_o     = cur_ff.rd_data;
  assign reg_rvalid_o    = cur_ff.rd_valid;
  assign core0_power_o   = cur_ff.eff_power0;
  assign core1_power_o   = cur_ff.eff_power1;
  assign skew_trim_o     = cur_ff.skew_trim;
  assign clock_div2_o    = (cur_ff.eff_divider == 2'h1);
  assign phase_slip_o    = cur_ff.slip_pulse;
  assign output_drive_o  = cur_ff.eff_drive;
  assign output_coding_o = cur_ff.eff_coding;
  assign ddr_enable_o    = cur_ff.format_sec[`DDR_BIT];
  assign dll_slow_o      = cur_ff.format_sec[`DLL_SLOW_BIT];
  assign test_active_o   = cur_ff.test_active;
  assign test_data_o     = cur_ff.test_data;

endmodule // adc_config_test_regs

`default_nettype wire

// >>> hdl/adc_cfg_params.svh
// register offsets, field positions, reset values and counts of the config bank
`ifndef ADC_CFG_PARAMS_SVH
`define ADC_CFG_PARAMS_SVH

// register offsets
`define ADDR_PORT_CONFIG   8'h00
`define ADDR_CORE_INDEX    8'h10
`define ADDR_POWER_MODE    8'h25
`define ADDR_SKEW_TRIM     8'h70
`define ADDR_CLOCK_SLIP    8'h71
`define ADDR_DIVIDER       8'h72
`define ADDR_FORMAT_PRI    8'h73
`define ADDR_FORMAT_SEC    8'h74
`define ADDR_DLL_STATE     8'h75
`define ADDR_TEST_CTRL     8'hC0
`define ADDR_WORD1_LOW     8'hC2
`define ADDR_WORD1_HIGH    8'hC3
`define ADDR_WORD2_LOW     8'hC4

// field positions
`define SOFT_RESET_BIT     5
`define SLIP_BIT           0
`define DDR_BIT            4
`define DLL_SLOW_BIT       6

// core index codes
`define INDEX_CORE0        8'h01
`define INDEX_CORE1        8'h10

// reset values and the code read back for a bad core index
`define RST_ZERO           8'h00
`define RST_SKEW           8'h80
`define BAD_INDEX_CODE     8'hAD

// one-hot mode codes of 3-bit fields
`define MODE_PIN           3'h0
`define MODE_SEL0          3'h1
`define MODE_SEL1          3'h2
`define MODE_SEL2          3'h4

// test pattern codes and words
`define PAT_OFF            4'h0
`define PAT_MID            4'h1
`define PAT_ONES           4'h2
`define PAT_ZEROS          4'h3
`define PAT_CHECKER        4'h4
`define PAT_ONE_ZERO       4'h7
`define PAT_USER           4'h8
`define WORD_MID           16'h8000
`define WORD_ONES          16'hFFFF
`define WORD_ZEROS         16'h0000
`define WORD_CHECK_A       16'hAAAA
`define WORD_CHECK_B       16'h5555

// settle cycles loaded on a test pattern change; the bus shows it one cycle after they run out
`define TEST_SETTLE        3'h4

`endif

// >>> hdl/adc_cfg_pkg.sv
// types of the converter configuration and test register bank
package adc_cfg_pkg;

  // decoded two-bit setting: 0,1,2 from one-hot codes 001,010,100
  typedef logic [1:0] setting_type;

  typedef struct packed {
    logic [7:0]  pin_meta;     // first sync stage of the four pins
    logic [7:0]  pin_sync;     // second sync stage
    logic [7:0]  core_index;
    logic [7:0]  power_core0;
    logic [7:0]  power_core1;
    logic [7:0]  skew_trim;
    logic [7:0]  clock_slip;
    logic [7:0]  divider;
    logic [7:0]  format_pri;
    logic [7:0]  format_sec;   // actual secondary format bits
    logic [7:0]  test_ctrl;
    logic [7:0]  word1_low;
    logic [7:0]  word1_high;
    logic [7:0]  word2_low;
    setting_type eff_power0;
    setting_type eff_power1;
    setting_type eff_divider;
    setting_type eff_drive;
    setting_type eff_coding;
    logic        eff_alt;
    logic [3:0]  eff_pattern;
    logic [2:0]  settle;
    logic        phase;
    logic        slip_pulse;
    logic [15:0] test_data;
    logic        test_active;
    logic [7:0]  rd_data;
    logic        rd_valid;
  } state_type;

endpackage

// >>> testbench/adc_cfg_checker.sv
// assertion checker for the converter configuration bank
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic [7:0]  skew_trim_o,
  input wire logic        clock_div2_o,
  input wire logic        phase_slip_o,
  input wire logic        ddr_enable_o,
  input wire logic        dll_slow_o,
  input wire logic        test_active_o,
  input wire logic [15:0] test_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // trim register and slip pulse
  skew_write_a: assert property (reg_wr_i && reg_addr_i == 8'h70 |=>
    skew_trim_o == $past(reg_wdata_i)) else $error("skew trim not updated");
  skew_reset_a: assert property ($rose(rst_n_i) |-> skew_trim_o == 8'h80)
    else $error("skew trim not centred after reset");
  slip_pulse_a: assert property (phase_slip_o |=> !phase_slip_o)
    else $error("slip pulse longer than one cycle");
  slip_cause_a: assert property (phase_slip_o |->
    $past(reg_wr_i && reg_addr_i == 8'h71 && reg_wdata_i[0])) else $error("slip without write");
  slip_div2_a: assert property (phase_slip_o |-> $past(clock_div2_o))
    else $error("slip outside divide by two");
  // secondary format xor write and status mirror
  format_xor_a: assert property (reg_wr_i && reg_addr_i == 8'h74 |-> ##2
    {ddr_enable_o, dll_slow_o} == ($past({ddr_enable_o, dll_slow_o}, 2)
    ^ $past({reg_wdata_i[4], reg_wdata_i[6]}, 2))) else $error("secondary format not toggled");
  status_read_a: assert property (reg_rd_i && reg_addr_i == 8'h75 |=>
    reg_rdata_o == {1'b0, dll_slow_o, 6'h00}) else $error("status read wrong");
  // test pattern output
  idle_data_a: assert property (!test_active_o |-> test_data_o == 16'h0000)
    else $error("pattern data while inactive");
  test_settle_a: assert property (reg_wr_i && reg_addr_i == 8'hC0 && !test_active_o
    |=> !test_active_o [*3]) else $error("pattern appeared too early");
endmodule // adc_cfg_checker
bind adc_config_test_regs adc_cfg_checker chk (.clk_i, .rst_n_i, .reg_wr_i, .reg_addr_i,
  .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .skew_trim_o, .clock_div2_o, .phase_slip_o,
  .ddr_enable_o, .dll_slow_o, .test_active_o, .test_data_o);
`default_nettype wire

// >>> testbench/adc_host_model.sv
// host model that writes and reads the register port
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic            wr_o = 1'b0,
  output logic            rd_o = 1'b0,
  output logic      [7:0] addr_o = 8'h00,
  output logic      [7:0] wdata_o = 8'h00
);
  // one write strobe, lines inverted once released
  task automatic put_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // one read strobe, bounded wait for the answer
  task automatic get_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    // answer sampled at the edge that closes its one-cycle window
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = rdata_i;
      end
    end
  endtask
  // slip request as a low then high bit 0
  task automatic slip;
    put_reg(8'h71, 8'h00);
    put_reg(8'h71, 8'h01);
  endtask
  // secondary format through readback of both registers
  task automatic set_sec(input logic [7:0] want);
    logic [7:0] b, s;
    logic ok;
    get_reg(8'h74, b, ok);
    get_reg(8'h75, s, ok);
    put_reg(8'h74, b ^ s ^ want);
  endtask
endmodule // adc_host_model
`default_nettype wire

// >>> testbench/test_adc_config_test_regs.sv
// self-checking bench for the converter configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_adc_config_test_regs;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, skew_trim_o;
  logic [1:0]  power_state_pin_i = 2'h0, divider_select_pin_i = 2'h0;
  logic [1:0]  output_drive_pin_i = 2'h0, output_coding_pin_i = 2'h0;
  logic [1:0]  core0_power_o, core1_power_o, output_drive_o, output_coding_o;
  logic        clock_div2_o, phase_slip_o, ddr_enable_o, dll_slow_o, test_active_o;
  logic [15:0] test_data_o;
  int          err_total = 0;
  int          num_checks = 0;
  always #12.5 clk_i = ~clk_i;
  adc_config_test_regs dut (.clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .power_state_pin_i, .divider_select_pin_i, .output_drive_pin_i, .output_coding_pin_i,
    .reg_rdata_o, .reg_rvalid_o, .core0_power_o, .core1_power_o, .skew_trim_o, .clock_div2_o,
    .phase_slip_o, .output_drive_o, .output_coding_o, .ddr_enable_o, .dll_slow_o,
    .test_active_o, .test_data_o);
  adc_host_model host (.clk_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.get_reg(a, d, ok);
    chk({8'h00, d}, {8'h00, exp});
    if (ok !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
    host.put_reg(a, d);
    cyc(n);
  endtask
  // trim reset value, index error code, unmapped read
  task automatic t_skew;
    chk(skew_trim_o, 16'h0080);
    rd_chk(8'h70, 8'h80);
    rd_chk(8'h25, 8'hAD);
    rd_chk(8'hC5, 8'h00);
    wr(8'h70, 8'hFF, 1);
    chk(skew_trim_o, 16'h00FF);
    wr(8'h70, 8'h00, 1);
    chk(skew_trim_o, 16'h0000);
  endtask
  // pin mode global, register mode per core, reserved code held
  task automatic t_power;
    @(posedge clk_i) power_state_pin_i <= 2'h1;
    cyc(5);
    chk({core0_power_o, core1_power_o}, 16'h0005);
    wr(8'h10, 8'h01, 0);
    wr(8'h25, 8'h04, 3);
    chk({core0_power_o, core1_power_o}, 16'h0009);
    rd_chk(8'h25, 8'h04);
    wr(8'h10, 8'h10, 0);
    wr(8'h25, 8'h01, 3);
    chk({core0_power_o, core1_power_o}, 16'h0008);
    wr(8'h25, 8'h02, 3);
    chk(core1_power_o, 16'h0001);
    wr(8'h25, 8'h03, 3);
    chk(core1_power_o, 16'h0001);
  endtask
  // divider select and phase slip
  task automatic t_div;
    @(posedge clk_i) divider_select_pin_i <= 2'h1;
    cyc(5);
    chk(clock_div2_o, 16'h0001);
    wr(8'h72, 8'h01, 3);
    chk(clock_div2_o, 16'h0000);
    wr(8'h72, 8'h02, 3);
    chk(clock_div2_o, 16'h0001);
    host.slip();
    cyc(0);
    chk(phase_slip_o, 16'h0001);
    cyc(1);
    chk(phase_slip_o, 16'h0000);
    wr(8'h71, 8'h01, 1);
    chk(phase_slip_o, 16'h0000);
    wr(8'h72, 8'h04, 3);
    chk(clock_div2_o, 16'h0001);
    wr(8'h72, 8'h01, 3);
    host.slip();
    cyc(0);
    chk(phase_slip_o, 16'h0000);
  endtask
  // drive and coding fields, every one-hot code
  task automatic t_format;
    for (int k = 0; k < 3; k++) begin
      wr(8'h73, {3'h1 << k, 2'h0, 3'h1 << ((k + 1) % 3)}, 3);
      chk(output_drive_o, 16'(k));
      chk(output_coding_o, 16'((k + 1) % 3));
    end
  endtask
  // secondary format set by the xor procedure
  task automatic t_ddr;
    chk(dll_slow_o, 16'h0000);
    host.set_sec(8'h50);
    cyc(3);
    chk({ddr_enable_o, dll_slow_o}, 16'h0003);
    rd_chk(8'h75, 8'h40);
    host.set_sec(8'h10);
    cyc(3);
    chk({ddr_enable_o, dll_slow_o}, 16'h0002);
    rd_chk(8'h75, 8'h00);
  endtask
  // user words alternating, then each preset in static mode
  task automatic t_test;
    logic [3:0]  codes[7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h5};
    logic [15:0] words[7] = '{16'h8000, 16'hFFFF, 16'h0000, 16'hAAAA, 16'hFFFF,
                              16'h1234, 16'h1234};
    logic [15:0] w;
    int i;
    wr(8'hC2, 8'h34, 0);
    wr(8'hC3, 8'h12, 0);
    wr(8'hC4, 8'h56, 0);
    wr(8'hC0, 8'h48, 0);
    for (i = 0; i < 20 && test_active_o !== 1'b1; i++) cyc(1);
    chk(test_active_o, 16'h0001);
    if (test_active_o !== 1'b1) conclude();
    w = test_data_o;
    cyc(1);
    chk(w ^ test_data_o, 16'h1262);
    chk((w === 16'h1234 || w === 16'h0056), 16'h0001);
    for (i = 0; i < 7; i++) begin
      wr(8'hC0, {4'h0, codes[i]}, 10);
      chk(test_data_o, words[i]);
      cyc(1);
      chk(test_data_o, words[i]);
    end
  endtask
  // soft reset clears most registers but keeps the exempt ones
  task automatic t_soft;
    wr(8'h70, 8'h11, 0);
    wr(8'h00, 8'h20, 4);
    chk(skew_trim_o, 16'h0080);
    chk(test_active_o, 16'h0000);
    chk({clock_div2_o, output_drive_o, core0_power_o}, 16'h000A);
    rd_chk(8'h72, 8'h01);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(1);
    t_skew();
    t_power();
    t_div();
    t_format();
    t_ddr();
    t_test();
    t_soft();
    conclude();
  end
endmodule // test_adc_config_test_regs
`default_nettype wire
